// ===== hw/dfpc_pkg.sv
`default_nettype none
package dfpc_pkg;

	// ------------------------------------------------------------------
	// widths and depths
	// ------------------------------------------------------------------
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int LANE_W    = 16;
	localparam int PTR_W     = 14;
	localparam int LVL_W     = 15;
	// 16K entries per port, whatever the port width
	localparam logic [LVL_W-1:0] FIFO_DEPTH   = 15'h4000;
	// dma ready drops with two slots left: one write may be in flight
	localparam logic [LVL_W-1:0] READY_LIMIT  = 15'h3FFE;

	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_OUT_PORT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_THRESH   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_CONFIG   = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h34;

	// ------------------------------------------------------------------
	// polarity bits, one per handshake signal
	// ------------------------------------------------------------------
	localparam int POL_IN_REQ  = 0;
	localparam int POL_IN_ACK  = 1;
	localparam int POL_IN_TRG  = 2;
	localparam int POL_OUT_REQ = 3;
	localparam int POL_OUT_ACK = 4;
	localparam int POL_OUT_TRG = 5;
	localparam logic [5:0] POL_RST = 6'h00;

	// ------------------------------------------------------------------
	// config register fields
	// ------------------------------------------------------------------
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_IN_EN      = 3;
	localparam int CFG_OUT_EN     = 4;
	localparam int CFG_IN_EXT     = 5;
	localparam int CFG_IN_WTRG    = 6;
	localparam int CFG_OUT_WTRG   = 7;
	localparam int CFG_OUT_WLVL   = 8;
	localparam int CFG_OUT_HSHK   = 9;
	localparam int CFG_IN_CLR     = 10;
	localparam int CFG_OUT_CLR    = 11;

	// ------------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------------
	localparam int ST_OVERRUN  = 0;
	localparam int ST_UNDERRUN = 1;
	localparam int ST_IN_EMPTY = 2;
	localparam int ST_IN_FULL  = 3;
	localparam int ST_OUT_EMPTY = 4;
	localparam int ST_OUT_FULL = 5;
	localparam int ST_IN_ARMED = 6;
	localparam int ST_OUT_RUN  = 7;
	localparam int ST_IN_AF    = 8;
	localparam int ST_OUT_AE   = 9;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [LANE_W-1:0] THR_AE_RST = 16'h0080;
	localparam logic [LANE_W-1:0] THR_AF_RST = 16'h0080;

	// ------------------------------------------------------------------
	// port arrangements
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ALL_INPUT_WIDE,
		ALL_OUTPUT_WIDE,
		HALF_IN_HALF_OUT,
		WIDE_IN_NARROW_OUT,
		NARROW_IN_WIDE_OUT,
		NARROW_IN_NARROW_OUT
	} dfpc_mode_e;
	localparam logic [2:0] MODE_RST = 3'h2;

	// lanes that carry input data in a mode
	function automatic logic [DATA_W-1:0] in_mask(input logic [2:0] m);
		case (m)
			3'h0:      in_mask = 32'hFFFFFFFF;
			3'h1:      in_mask = 32'h00000000;
			3'h4, 3'h5: in_mask = 32'h000000FF;
			default:   in_mask = 32'h0000FFFF;
		endcase
	endfunction

	// lanes that carry output data in a mode
	function automatic logic [DATA_W-1:0] out_mask(input logic [2:0] m);
		case (m)
			3'h0:      out_mask = 32'h00000000;
			3'h1:      out_mask = 32'hFFFFFFFF;
			3'h3, 3'h5: out_mask = 32'h000000FF;
			default:   out_mask = 32'h0000FFFF;
		endcase
	endfunction

endpackage
`default_nettype wire

// ===== hw/dfpc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dfpc_fifo (
	// clock and reset
	input  wire logic                         mclk_i,
	input  wire logic                         sys_rst_i,
	// control
	input  wire logic                         clr_i,
	input  wire logic [dfpc_pkg::LANE_W-1:0]  ae_thr_i,
	input  wire logic [dfpc_pkg::LANE_W-1:0]  af_thr_i,
	// write side
	input  wire logic                         wr_i,
	input  wire logic [dfpc_pkg::LANE_W-1:0]  wd_i,
	// read side, head shown ahead
	input  wire logic                         rd_i,
	output logic      [dfpc_pkg::LANE_W-1:0]  rq_o,
	// flags
	output logic                              empty_o,
	output logic                              full_o,
	output logic                              almost_empty_o,
	output logic                              almost_full_o,
	output logic      [dfpc_pkg::LVL_W-1:0]   level_o
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [dfpc_pkg::PTR_W-1:0] wp;
		logic [dfpc_pkg::PTR_W-1:0] rp;
		logic [dfpc_pkg::LVL_W-1:0] lvl;
	} dfpc_fifo_s;

	dfpc_fifo_s                 s;
	dfpc_fifo_s                 next_s;
	logic [dfpc_pkg::LANE_W-1:0] mem [0:16383];
	logic                       do_wr;
	logic                       do_rd;

	assign empty_o = (s.lvl == '0);
	assign full_o  = (s.lvl == dfpc_pkg::FIFO_DEPTH);
	assign level_o = s.lvl;
	assign rq_o    = mem[s.rp];
	assign almost_empty_o = ({1'b0, s.lvl} <= ae_thr_i);
	assign almost_full_o  =
		({1'b0, dfpc_pkg::FIFO_DEPTH - s.lvl} <= af_thr_i);
	// overflow and underflow are refused here, whatever the caller asks
	assign do_wr = wr_i & ~full_o & ~clr_i;
	assign do_rd = rd_i & ~empty_o & ~clr_i;

	always_comb begin
		next_s = s;
		if (clr_i) begin
			next_s = '0;
		end else begin
			if (do_wr) begin
				next_s.wp = s.wp + 1'b1;
			end
			if (do_rd) begin
				next_s.rp = s.rp + 1'b1;
			end
			case ({do_wr, do_rd})
				2'b10:   next_s.lvl = s.lvl + 1'b1;
				2'b01:   next_s.lvl = s.lvl - 1'b1;
				default: next_s.lvl = s.lvl;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// storage carries no reset, so it maps onto block memory
	always_ff @(posedge mclk_i) begin
		if (do_wr) begin
			mem[s.wp] <= wd_i;
		end
	end

endmodule
`default_nettype wire

// ===== hw/dfpc_top.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - access port lanes follow output width
// - access port inert when both ports input
// - threshold register write-only, second port low
// - two writes: almost-empty then almost-full
// - six polarity bits, one selects falling edge
// - six port arrangements, half/half default
// - wide input: second port extends, controls off
// - wide output: first port extends, controls off
// - line 0 lsb, line 31 msb
// - reset gives 16-bit, first in, second out
// - 8-bit width uses lower byte only
// - 32-bit width moves both ports together
// - two 16K-word fifos, one per port
// - depth 16K entries at every width
// - sample and send at configured pace
// - non-empty input fifo offered to dma
// - full input fifo drops samples, flags overrun
// - full output fifo stalls dma writes
// - empty output fifo holds value, flags underrun
// - level start waits above almost-empty
// - acknowledge while input not almost full
module dfpc_top (
	// clock and reset
	input  wire logic                           mclk_i,
	input  wire logic                           sys_rst_i,
	// register port
	input  wire logic [dfpc_pkg::ADDR_W-1:0]    reg_addr_i,
	input  wire logic [dfpc_pkg::DATA_W-1:0]    reg_wdata_i,
	input  wire logic                           reg_wr_i,
	input  wire logic                           reg_rd_i,
	output logic      [dfpc_pkg::DATA_W-1:0]    reg_rdata_o,
	// pacer ticks from the timer
	input  wire logic                           in_tick_i,
	input  wire logic                           out_tick_i,
	// dma side, input stream
	output logic                                in_valid_o,
	output logic      [dfpc_pkg::DATA_W-1:0]    in_data_o,
	input  wire logic                           in_ready_i,
	// dma side, output stream
	input  wire logic                           out_valid_i,
	input  wire logic [dfpc_pkg::DATA_W-1:0]    out_data_i,
	output logic                                out_ready_o,
	// data pins
	input  wire logic [dfpc_pkg::LANE_W-1:0]    first_port_i,
	output logic      [dfpc_pkg::LANE_W-1:0]    first_port_o,
	output logic                                first_port_oe_o,
	input  wire logic [dfpc_pkg::LANE_W-1:0]    second_port_i,
	output logic      [dfpc_pkg::LANE_W-1:0]    second_port_o,
	output logic                                second_port_oe_o,
	// handshake pins
	input  wire logic                           input_request_i,
	output logic                                input_acknowledge_o,
	input  wire logic                           input_trigger_i,
	output logic                                output_request_o,
	input  wire logic                           output_acknowledge_i,
	input  wire logic                           output_trigger_i
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  mode;
		logic        in_en;
		logic        out_en;
		logic        in_ext;
		logic        in_wtrg;
		logic        out_wtrg;
		logic        out_wlvl;
		logic        out_hshk;
		logic [5:0]  pol;
		logic        thr_second;
		logic [15:0] ae0;
		logic [15:0] af0;
		logic [15:0] ae1;
		logic [15:0] af1;
		logic        overrun;
		logic        underrun;
		logic        in_armed;
		logic        out_trig_seen;
		logic        out_run;
		logic [31:0] pin_s1;
		logic [31:0] pin_s2;
		logic [3:0]  hs_s1;
		logic [3:0]  hs_s2;
		logic [3:0]  hs_prev;
		logic [31:0] out_word;
		logic [15:0] first_out;
		logic        first_oe;
		logic [15:0] second_out;
		logic        second_oe;
		logic        out_req;
		logic        in_ack;
		logic        in_valid;
		logic [31:0] in_data;
		logic        out_ready;
		logic [31:0] rdata;
	} dfpc_state_s;

	dfpc_state_s s;
	dfpc_state_s next_s;

	// fifo hookup: index 0 belongs to the first port, 1 to the second
	logic [1:0]        f_clr;
	logic [1:0]        f_wr;
	logic [1:0]        f_rd;
	logic [1:0]        f_empty;
	logic [1:0]        f_full;
	logic [1:0]        f_ae;
	logic [1:0]        f_af;
	logic [1:0][15:0]  f_wd;
	logic [1:0][15:0]  f_q;
	logic [1:0][14:0]  f_lvl;
	logic [1:0][15:0]  f_aethr;
	logic [1:0][15:0]  f_afthr;

	// ------------------------------------------------------------------
	// fifos
	// ------------------------------------------------------------------
	assign f_aethr = {s.ae1, s.ae0};
	assign f_afthr = {s.af1, s.af0};

	for (genvar g = 0; g < 2; g++) begin : g_fifo
		dfpc_fifo u_fifo (
			.mclk_i         (mclk_i),
			.sys_rst_i      (sys_rst_i),
			.clr_i          (f_clr[g]),
			.ae_thr_i       (f_aethr[g]),
			.af_thr_i       (f_afthr[g]),
			.wr_i           (f_wr[g]),
			.wd_i           (f_wd[g]),
			.rd_i           (f_rd[g]),
			.rq_o           (f_q[g]),
			.empty_o        (f_empty[g]),
			.full_o         (f_full[g]),
			.almost_empty_o (f_ae[g]),
			.almost_full_o  (f_af[g]),
			.level_o        (f_lvl[g])
		);
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic        wide_in;
		logic        wide_out;
		logic [31:0] imask;
		logic [31:0] omask;
		logic [3:0]  edge_hit;
		logic        in_clr;
		logic        out_clr;
		logic        in_empty;
		logic        in_full;
		logic        in_af;
		logic        out_empty;
		logic        out_full;
		logic        out_ae;
		logic [31:0] in_head;
		logic [31:0] out_head;
		logic        sample;
		logic        send;
		logic        in_push;
		logic        in_pop;
		logic        out_push;
		logic        out_pop;
		logic [31:0] out_wd;
		logic        wr_hit_out;
		logic        dma_take;
		next_s     = s;
		wide_in    = (s.mode == 3'(dfpc_pkg::ALL_INPUT_WIDE));
		wide_out   = (s.mode == 3'(dfpc_pkg::ALL_OUTPUT_WIDE));
		imask      = dfpc_pkg::in_mask(s.mode);
		omask      = dfpc_pkg::out_mask(s.mode);
		in_clr     = reg_wr_i & (reg_addr_i == dfpc_pkg::OFS_CONFIG)
			& reg_wdata_i[dfpc_pkg::CFG_IN_CLR];
		out_clr    = reg_wr_i & (reg_addr_i == dfpc_pkg::OFS_CONFIG)
			& reg_wdata_i[dfpc_pkg::CFG_OUT_CLR];

		// combined views; 32-bit modes join both fifos as one word
		in_empty  = f_empty[0] | (wide_in & f_empty[1]);
		in_full   = f_full[0] | (wide_in & f_full[1]);
		in_af     = f_af[0] | (wide_in & f_af[1]);
		out_empty = f_empty[1] | (wide_out & f_empty[0]);
		out_full  = f_full[1] | (wide_out & f_full[0]);
		out_ae    = f_ae[1] | (wide_out & f_ae[0]);
		in_head   = {wide_in ? f_q[1] : 16'h0000, f_q[0]};
		out_head  = {wide_out ? f_q[0] : 16'h0000, f_q[1]};

		// polarity sits ahead of the synchronisers, so all later
		// logic sees active-high edges
		next_s.pin_s1 = {second_port_i, first_port_i};
		next_s.pin_s2 = s.pin_s1;
		next_s.hs_s1  = {output_trigger_i ^ s.pol[dfpc_pkg::POL_OUT_TRG],
			output_acknowledge_i ^ s.pol[dfpc_pkg::POL_OUT_ACK],
			input_trigger_i ^ s.pol[dfpc_pkg::POL_IN_TRG],
			input_request_i ^ s.pol[dfpc_pkg::POL_IN_REQ]};
		next_s.hs_s2   = s.hs_s1;
		next_s.hs_prev = s.hs_s2;
		edge_hit       = s.hs_s2 & ~s.hs_prev;
		// controls of the port that only extends the other are ignored
		if (wide_in) begin
			edge_hit[3:2] = 2'b00;
		end
		if (wide_out) begin
			edge_hit[1:0] = 2'b00;
		end

		// input side
		if (!s.in_en) begin
			next_s.in_armed = 1'b0;
		end else if (!s.in_wtrg || edge_hit[1]) begin
			next_s.in_armed = 1'b1;
		end
		sample  = s.in_en & s.in_armed & ~wide_out
			& (s.in_ext ? edge_hit[0] : in_tick_i);
		in_push = sample & ~in_full & ~in_clr;
		if (sample && in_full) begin
			next_s.overrun = 1'b1;
		end
		next_s.in_ack = (s.in_en & ~in_af & ~wide_out)
			^ s.pol[dfpc_pkg::POL_IN_ACK];

		// dma take-off register: one word held until the dma takes it
		in_pop = ~in_empty & ~in_clr & (~s.in_valid | in_ready_i);
		if (in_clr) begin
			next_s.in_valid = 1'b0;
		end else if (in_pop) begin
			next_s.in_valid = 1'b1;
			next_s.in_data  = in_head;
		end else if (in_ready_i) begin
			next_s.in_valid = 1'b0;
		end

		// output fifo filling; a dma beat beats a bus write in the
		// same cycle, and the bus write is then lost
		dma_take   = out_valid_i & s.out_ready & ~wide_in;
		wr_hit_out = reg_wr_i & (reg_addr_i == dfpc_pkg::OFS_OUT_PORT)
			& ~wide_in;
		out_wd   = (dma_take ? out_data_i : reg_wdata_i) & omask;
		out_push = (dma_take | wr_hit_out) & ~out_full & ~out_clr;
		next_s.out_ready = ~out_clr & ~wide_in
			& ((wide_out ? f_lvl[0] : f_lvl[1]) < dfpc_pkg::READY_LIMIT);

		// output start and pacing
		if (!s.out_en) begin
			next_s.out_trig_seen = 1'b0;
			next_s.out_run       = 1'b0;
		end else begin
			if (edge_hit[3]) begin
				next_s.out_trig_seen = 1'b1;
			end
			if ((!s.out_wtrg || s.out_trig_seen)
				&& (!s.out_wlvl || !out_ae)) begin
				next_s.out_run = 1'b1;
			end
		end
		send    = s.out_run & ~wide_in
			& (s.out_hshk ? edge_hit[2] : out_tick_i);
		out_pop = send & ~out_empty & ~out_clr;
		next_s.out_req = out_pop ^ s.pol[dfpc_pkg::POL_OUT_REQ];
		if (out_pop) begin
			next_s.out_word = out_head & omask;
		end
		if (send && out_empty) begin
			next_s.underrun = 1'b1;
		end

		// pins; output lanes of both ports change on one edge
		next_s.second_out = wide_in ? 16'h0000 : s.out_word[15:0];
		next_s.second_oe  = ~wide_in;
		next_s.first_out  = wide_out ? s.out_word[31:16] : 16'h0000;
		next_s.first_oe   = wide_out;

		// fifo routing
		f_clr = wide_out ? {out_clr, out_clr} : (wide_in ?
			{in_clr, in_clr} : {out_clr, in_clr});
		f_wr[0] = wide_out ? out_push : in_push;
		f_wd[0] = wide_out ? out_wd[31:16]
			: (s.pin_s2[15:0] & imask[15:0]);
		f_wr[1] = wide_in ? in_push : out_push;
		f_wd[1] = wide_in ? s.pin_s2[31:16] : out_wd[15:0];
		f_rd[0] = wide_out ? out_pop : in_pop;
		f_rd[1] = wide_in ? in_pop : out_pop;

		// register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				dfpc_pkg::OFS_THRESH: begin
					if (!s.thr_second) begin
						next_s.ae1 = reg_wdata_i[15:0];
						next_s.ae0 = reg_wdata_i[31:16];
					end else begin
						next_s.af1 = reg_wdata_i[15:0];
						next_s.af0 = reg_wdata_i[31:16];
					end
					next_s.thr_second = ~s.thr_second;
				end
				dfpc_pkg::OFS_POLARITY: begin
					next_s.pol = reg_wdata_i[5:0];
				end
				dfpc_pkg::OFS_CONFIG: begin
					if (reg_wdata_i[2:0] <= 3'h5) begin
						next_s.mode = reg_wdata_i[2:0];
					end
					next_s.in_en    = reg_wdata_i[dfpc_pkg::CFG_IN_EN];
					next_s.out_en   = reg_wdata_i[dfpc_pkg::CFG_OUT_EN];
					next_s.in_ext   = reg_wdata_i[dfpc_pkg::CFG_IN_EXT];
					next_s.in_wtrg  = reg_wdata_i[dfpc_pkg::CFG_IN_WTRG];
					next_s.out_wtrg = reg_wdata_i[dfpc_pkg::CFG_OUT_WTRG];
					next_s.out_wlvl = reg_wdata_i[dfpc_pkg::CFG_OUT_WLVL];
					next_s.out_hshk = reg_wdata_i[dfpc_pkg::CFG_OUT_HSHK];
				end
				dfpc_pkg::OFS_STATUS: begin
					// hardware set above wins over this clear
					if (reg_wdata_i[dfpc_pkg::ST_OVERRUN]
						&& !(sample && in_full)) begin
						next_s.overrun = 1'b0;
					end
					if (reg_wdata_i[dfpc_pkg::ST_UNDERRUN]
						&& !(send && out_empty)) begin
						next_s.underrun = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (in_clr || out_clr) begin
			next_s.thr_second = 1'b0;
		end

		// register reads, answered in the next cycle
		next_s.rdata = 32'h00000000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				dfpc_pkg::OFS_OUT_PORT: begin
					// peek only: reading does not pop the fifo
					next_s.rdata = out_head & omask;
				end
				dfpc_pkg::OFS_POLARITY: begin
					next_s.rdata = {26'h0000000, s.pol};
				end
				dfpc_pkg::OFS_CONFIG: begin
					next_s.rdata = {22'h000000, s.out_hshk, s.out_wlvl,
						s.out_wtrg, s.in_wtrg, s.in_ext, s.out_en, s.in_en,
						s.mode};
				end
				dfpc_pkg::OFS_STATUS: begin
					next_s.rdata = {22'h000000, out_ae, in_af, s.out_run,
						s.in_armed, out_full, out_empty, in_full, in_empty,
						s.underrun, s.overrun};
				end
				default: begin
					next_s.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s            <= '0;
			s.mode       <= dfpc_pkg::MODE_RST;
			s.pol        <= dfpc_pkg::POL_RST;
			s.ae0        <= dfpc_pkg::THR_AE_RST;
			s.ae1        <= dfpc_pkg::THR_AE_RST;
			s.af0        <= dfpc_pkg::THR_AF_RST;
			s.af1        <= dfpc_pkg::THR_AF_RST;
			s.second_oe  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reg_rdata_o         = s.rdata;
	assign in_valid_o          = s.in_valid;
	assign in_data_o           = s.in_data;
	assign out_ready_o         = s.out_ready;
	assign first_port_o        = s.first_out;
	assign first_port_oe_o     = s.first_oe;
	assign second_port_o       = s.second_out;
	assign second_port_oe_o    = s.second_oe;
	assign input_acknowledge_o = s.in_ack;
	assign output_request_o    = s.out_req;

endmodule
`default_nettype wire

// ===== verification/dfpc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dfpc_top_chk (
	// clock and register port
	input wire logic        mclk_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// dma and pins
	input wire logic        in_valid_o,
	input wire logic [31:0] in_data_o,
	input wire logic        in_ready_i,
	input wire logic        first_port_oe_o,
	input wire logic        second_port_oe_o,
	input wire logic        input_acknowledge_o,
	input wire logic        output_request_o
);
	// shadow of polarity and mode, kept from bus writes only
	logic [5:0] pol;
	logic [2:0] mode;
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pol  <= dfpc_pkg::POL_RST;
			mode <= dfpc_pkg::MODE_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == dfpc_pkg::OFS_POLARITY)
				pol <= reg_wdata_i[5:0];
			if (reg_addr_i == dfpc_pkg::OFS_CONFIG && reg_wdata_i[2:0] < 3'h6)
				mode <= reg_wdata_i[2:0];
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	property p_thr_wo;
		$past(reg_rd_i && reg_addr_i == dfpc_pkg::OFS_THRESH)
			|-> reg_rdata_o == 32'h0;
	endproperty
	a_thr_wo: assert property (p_thr_wo)
		else $error("threshold register read back");
	property p_pol_rd;
		$past(reg_rd_i && reg_addr_i == dfpc_pkg::OFS_POLARITY)
			|-> reg_rdata_o[5:0] == $past(pol);
	endproperty
	a_pol_rd: assert property (p_pol_rd)
		else $error("polarity readback differs");
	property p_in_hold;
		in_valid_o && !in_ready_i |=> in_valid_o && $stable(in_data_o);
	endproperty
	a_in_hold: assert property (p_in_hold)
		else $error("input word dropped before taken");
	property p_rst_dir;
		$fell(sys_rst_i) |-> second_port_oe_o && !first_port_oe_o;
	endproperty
	a_rst_dir: assert property (p_rst_dir)
		else $error("port direction wrong after reset");
	property p_req_pulse;
		output_request_o != pol[3] && $stable(pol) |=> output_request_o == pol[3];
	endproperty
	a_req_pulse: assert property (p_req_pulse)
		else $error("output request longer than one cycle");
	property p_wide_in;
		mode == 3'h0 && $past(mode) == 3'h0 && $stable(pol)
			|-> output_request_o == pol[3];
	endproperty
	a_wide_in: assert property (p_wide_in)
		else $error("output request active in wide input");
	property p_wide_out;
		mode == 3'h1 && $past(mode) == 3'h1 && $stable(pol)
			|-> input_acknowledge_o == pol[1] && first_port_oe_o;
	endproperty
	a_wide_out: assert property (p_wide_out)
		else $error("first port controls live in wide output");
	property p_acc_dead;
		$past(reg_rd_i && reg_addr_i == dfpc_pkg::OFS_OUT_PORT && mode == 3'h0)
			|-> reg_rdata_o == 32'h0;
	endproperty
	a_acc_dead: assert property (p_acc_dead)
		else $error("access port live with both ports input");
	c_in_take: cover property (in_valid_o && in_ready_i);
	c_out_send: cover property (output_request_o != pol[3]);
	c_wide_out: cover property (mode == 3'h1);
endmodule
bind dfpc_top dfpc_top_chk i_dfpc_top_chk (.mclk_i, .sys_rst_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .in_valid_o, .in_data_o,
	.in_ready_i, .first_port_oe_o, .second_port_oe_o, .input_acknowledge_o,
	.output_request_o);
`default_nettype wire

// ===== verification/dfpc_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none
module dfpc_ext_dev (
	// words the device presents
	input  wire logic [15:0] word_a_i,
	input  wire logic [15:0] word_b_i,
	// block side of the pins
	input  wire logic [15:0] blk_a_i,
	input  wire logic        blk_a_oe_i,
	input  wire logic [15:0] blk_b_i,
	input  wire logic        blk_b_oe_i,
	// resolved pin levels
	output logic      [15:0] pin_a_o,
	output logic      [15:0] pin_b_o,
	output logic             request_o
);
	// device lets go of a port the block drives
	assign pin_a_o = blk_a_oe_i ? blk_a_i : word_a_i;
	assign pin_b_o = blk_b_oe_i ? blk_b_i : word_b_i;
	// pacing is by tick, so request stays idle: never sent without ack
	assign request_o = 1'b0;
endmodule
`default_nettype wire

// ===== verification/dfpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dfpc_top_tb;
	logic        mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0, in_tick_i = 1'b0, out_tick_i = 1'b0;
	logic        in_ready_i = 1'b0, out_valid_i = 1'b0, input_request_i;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, out_data_i = 32'h0, d;
	logic [15:0] word_a = 16'h0, word_b = 16'h0, pa, pb;
	logic [31:0] reg_rdata_o, in_data_o;
	logic [15:0] first_port_o, second_port_o;
	logic        in_valid_o, out_ready_o, first_port_oe_o, second_port_oe_o;
	logic        input_acknowledge_o, output_request_o;
	int          err_count = 0, num_checks = 0;
	dfpc_top i_dfpc_top (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .in_tick_i, .out_tick_i,
		.in_valid_o, .in_data_o, .in_ready_i, .out_valid_i, .out_data_i,
		.out_ready_o, .first_port_i(pa), .first_port_o, .first_port_oe_o,
		.second_port_i(pb), .second_port_o, .second_port_oe_o,
		.input_request_i, .input_acknowledge_o, .input_trigger_i(1'b0),
		.output_request_o, .output_acknowledge_i(1'b0),
		.output_trigger_i(1'b0));
	dfpc_ext_dev i_dfpc_ext_dev (.word_a_i(word_a), .word_b_i(word_b),
		.blk_a_i(first_port_o), .blk_a_oe_i(first_port_oe_o),
		.blk_b_i(second_port_o), .blk_b_oe_i(second_port_oe_o),
		.pin_a_o(pa), .pin_b_o(pb), .request_o(input_request_i));
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_wr_i    <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rc(string n, logic [7:0] a, logic [31:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
		chk(n, e, d);
	endtask
	task automatic tick_out;
		@(posedge mclk_i);
		out_tick_i <= 1'b1;
		@(posedge mclk_i);
		out_tick_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
	endtask
	// pins need two cycles to pass the synchroniser before the tick
	task automatic take_in(string n, logic [31:0] e);
		repeat (4) @(posedge mclk_i);
		in_tick_i <= 1'b1;
		@(posedge mclk_i);
		in_tick_i <= 1'b0;
		for (int k = 0; k < 20 && in_valid_o !== 1'b1; k++) begin
			@(posedge mclk_i);
			#1;
		end
		chk(n, e, in_data_o);
		@(posedge mclk_i);
		in_ready_i <= 1'b1;
		@(posedge mclk_i);
		in_ready_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1 chk("in_valid", 32'h0, {31'h0, in_valid_o});
	endtask
	task automatic t_regs;
		chk("oe", 32'h1, {first_port_oe_o, second_port_oe_o});
		rc("config", dfpc_pkg::OFS_CONFIG, 32'h2);
		wr(dfpc_pkg::OFS_THRESH, 32'h00200010);
		wr(dfpc_pkg::OFS_THRESH, 32'h00400030);
		rc("thresh", dfpc_pkg::OFS_THRESH, 32'h0);
		wr(dfpc_pkg::OFS_POLARITY, 32'h2A);
		rc("pol", dfpc_pkg::OFS_POLARITY, 32'h2A);
		chk("idle", 32'h3, {output_request_o, input_acknowledge_o});
		wr(dfpc_pkg::OFS_POLARITY, 32'h0);
	endtask
	task automatic t_out;
		wr(dfpc_pkg::OFS_CONFIG, 32'h15);
		wr(dfpc_pkg::OFS_OUT_PORT, 32'hA5A51234);
		rc("peek8", dfpc_pkg::OFS_OUT_PORT, 32'h34);
		tick_out;
		chk("out8", 32'h34, {16'h0, second_port_o});
		tick_out;
		chk("hold", 32'h34, {16'h0, second_port_o});
		rc("status", dfpc_pkg::OFS_STATUS, 32'h00000296);
		chk("underrun", 32'h1, {31'h0, d[1]});
		wr(dfpc_pkg::OFS_CONFIG, 32'h12);
		@(posedge mclk_i);
		out_valid_i <= 1'b1;
		out_data_i  <= 32'hFFFF8421;
		@(posedge mclk_i);
		out_valid_i <= 1'b0;
		tick_out;
		chk("out16", 32'h8421, {16'h0, second_port_o});
	endtask
	task automatic t_in;
		word_a = 16'hBEEF;
		word_b = 16'h5678;
		wr(dfpc_pkg::OFS_CONFIG, 32'hC);
		take_in("in8", 32'h000000EF);
		wr(dfpc_pkg::OFS_CONFIG, 32'hA);
		take_in("in16", 32'h0000BEEF);
		wr(dfpc_pkg::OFS_CONFIG, 32'h8);
		take_in("in32", 32'h5678BEEF);
		chk("oe32", 32'h0, {first_port_oe_o, second_port_oe_o});
		wr(dfpc_pkg::OFS_OUT_PORT, 32'h1);
		rc("dead", dfpc_pkg::OFS_OUT_PORT, 32'h0);
		wr(dfpc_pkg::OFS_CONFIG, 32'h1);
		wr(dfpc_pkg::OFS_OUT_PORT, 32'hFFFF8421);
		rc("peek32", dfpc_pkg::OFS_OUT_PORT, 32'hFFFF8421);
		chk("oe_out", 32'h3, {first_port_oe_o, second_port_oe_o});
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#1000000;
		err_count++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		t_regs;
		t_out;
		t_in;
		finish_test;
	end
endmodule
`default_nettype wire
